// ### ctpg_gen.sv
// Test pattern generator: byte registers, frame sequencer and pattern source
`include "ctpg_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// R1: Frames generated only while enable bit set
// R2: Config bit 7 picks bars or fixed
// R3: Bar count code gives 1,2,4,8 bars
// R4: Block size sets repeated block length
// R5: Packets carry programmed virtual channel
// R6: Packets carry programmed data type, reset 0x24
// R7: Line length is 16 bits, two bytes
// R8: Line length resets to 1920 bytes
// R9: Bar width from 16-bit two-byte value
// R10: Last bar fills remainder of line
// R11: Active lines 16 bits, reset 480
// R12: Each line lasts programmed period
// R13: Top blank lines after frame start
// R14: Bottom blank lines before frame end
// R15: Colour registers supply bar/block bytes
// R16: Disabled sends nothing; start at frame
module ctpg_gen
  import ctpg_pkg::*;
#(
  parameter logic [7:0] COLOR_RESET = 8'h00,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Packet byte stream toward the transmitter
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_first,
  output logic tx_last,
  // Status
  output logic frame_active
);
  localparam int NREG = 30;

  // R8 R11 register reset values
  function automatic ctpg_byte_t reg_reset(input logic [7:0] a);
    unique case (a)
      `CTPG_ADDR_CTL: return `CTPG_RST_CTL;
      `CTPG_ADDR_CFG: return `CTPG_RST_CFG;
      `CTPG_ADDR_IDS: return `CTPG_RST_IDS;
      `CTPG_ADDR_LINE_HI: return `CTPG_RST_LINE_HI;
      `CTPG_ADDR_LINE_LO: return `CTPG_RST_LINE_LO;
      `CTPG_ADDR_BAR_HI: return `CTPG_RST_BAR_HI;
      `CTPG_ADDR_BAR_LO: return `CTPG_RST_BAR_LO;
      `CTPG_ADDR_ACT_HI: return `CTPG_RST_ACT_HI;
      `CTPG_ADDR_ACT_LO: return `CTPG_RST_ACT_LO;
      `CTPG_ADDR_TOT_HI: return `CTPG_RST_TOT_HI;
      `CTPG_ADDR_TOT_LO: return `CTPG_RST_TOT_LO;
      `CTPG_ADDR_PD_HI: return `CTPG_RST_PD_HI;
      `CTPG_ADDR_PD_LO: return `CTPG_RST_PD_LO;
      `CTPG_ADDR_TOP: return `CTPG_RST_TOP;
      `CTPG_ADDR_BOT: return `CTPG_RST_BOT;
      `CTPG_ADDR_COLOR0: return `CTPG_RST_COLOR0;
      `CTPG_ADDR_COLOR0 + 8'h01: return `CTPG_RST_COLOR1;
      default: return COLOR_RESET;
    endcase
  endfunction : reg_reset

  // Reserved bits are not writable and read back as zero
  function automatic ctpg_byte_t reg_mask(input logic [7:0] a);
    if (a == `CTPG_ADDR_CTL)
      return `CTPG_MASK_CTL;
    else if (a == `CTPG_ADDR_CFG)
      return `CTPG_MASK_CFG;
    else
      return 8'hFF;
  endfunction : reg_mask

  // Address to slot; regs is indexed in place so readers see every write
  function automatic logic [4:0] slot(input logic [7:0] a);
    return 5'(a - `CTPG_ADDR_CTL);
  endfunction : slot

  ctpg_byte_t regs [0:NREG-1];
  wire addr_hit = (reg_addr >= `CTPG_ADDR_CTL) && (reg_addr <= `CTPG_ADDR_LAST);
  wire [4:0] addr_idx = slot(reg_addr);

  for (genvar i = 0; i < NREG; i++)
  begin : g_reg
    localparam logic [7:0] A = 8'(i + 1);
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
        regs[i] <= reg_reset(A);
      else if (reg_wr && addr_hit && addr_idx == 5'(i))
        regs[i] <= reg_wdata & reg_mask(A);
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= addr_hit ? regs[addr_idx] : 8'h00;
  end

  // Field decode
  wire ctpg_byte_t ctl = regs[slot(`CTPG_ADDR_CTL)];
  wire ctpg_byte_t cfg = regs[slot(`CTPG_ADDR_CFG)];
  wire ctpg_byte_t ids = regs[slot(`CTPG_ADDR_IDS)];
  wire generator_on = ctl[`CTPG_BIT_ENABLE];
  wire solid_pattern_select = cfg[`CTPG_BIT_SOLID];
  wire [1:0] bar_count_code = cfg[`CTPG_BAR_CODE_HI:`CTPG_BAR_CODE_LO];
  wire [3:0] block_size = cfg[`CTPG_BLOCK_HI:`CTPG_BLOCK_LO];
  wire [1:0] packet_virtual_channel = ids[`CTPG_VC_HI:`CTPG_VC_LO];
  wire [5:0] packet_data_type = ids[`CTPG_DT_HI:`CTPG_DT_LO];
  // R7 line length from two byte registers
  wire [15:0] active_line_bytes = {regs[slot(`CTPG_ADDR_LINE_HI)],
                                   regs[slot(`CTPG_ADDR_LINE_LO)]};
  // R9 bar width from two byte registers
  wire [15:0] bar_width_bytes = {regs[slot(`CTPG_ADDR_BAR_HI)],
                                 regs[slot(`CTPG_ADDR_BAR_LO)]};
  // R11 active line count
  wire [15:0] active_line_count = {regs[slot(`CTPG_ADDR_ACT_HI)],
                                   regs[slot(`CTPG_ADDR_ACT_LO)]};
  wire [15:0] line_period_ticks = {regs[slot(`CTPG_ADDR_PD_HI)],
                                   regs[slot(`CTPG_ADDR_PD_LO)]};
  wire [7:0] top_blank_lines = regs[slot(`CTPG_ADDR_TOP)];
  wire [7:0] bottom_blank_lines = regs[slot(`CTPG_ADDR_BOT)];

  ctpg_state_t state;
  ctpg_state_t next_state;
  logic [1:0] hdr_idx;
  logic [15:0] pay_cnt;
  logic [2:0] bar_idx;
  logic [15:0] bar_pos;
  logic [3:0] blk_idx;
  logic [15:0] line_idx;
  logic [7:0] blank_cnt;
  logic [15:0] frame_num;
  logic line_end;

  // Held while off, so the first frame starts one full line after enable
  ctpg_line_timer u_timer (
    .clk(clk),
    .resetn(resetn),
    .hold(!generator_on),
    .period(line_period_ticks),
    .line_end(line_end)
  );

  ctpg_stream_if #(.WIDTH(10)) gen_bus ();
  ctpg_stream_if #(.WIDTH(10)) out_bus ();

  // Buffer absorbs short sink stalls without slipping the line timing
  ctpg_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .wr(gen_bus.snk),
    .rd(out_bus.src)
  );

  assign tx_valid = out_bus.valid;
  assign out_bus.ready = tx_ready;
  assign {tx_first, tx_last, tx_data} = out_bus.data;

  // Byte source
  wire is_short = (state == CTPG_FS) || (state == CTPG_FE);
  wire emitting = is_short || (state == CTPG_HDR) || (state == CTPG_PAY);
  wire push = emitting && gen_bus.ready;
  wire hdr_done = (hdr_idx == `CTPG_HDR_BYTES - 2'h1);
  wire pay_done = (pay_cnt == active_line_bytes - 16'h0001);
  wire last_line = (line_idx == active_line_count - 16'h0001);
  wire [5:0] short_type = (state == CTPG_FS) ? `CTPG_DT_FRAME_START : `CTPG_DT_FRAME_END;
  // R5 R6 channel and type in each header
  wire [5:0] hdr_type = is_short ? short_type : packet_data_type;
  wire [15:0] hdr_field = is_short ? frame_num : active_line_bytes;

  // R3 code n gives 2**n bars
  wire [2:0] last_bar = 3'((4'h1 << bar_count_code) - 4'h1);
  // R10 final bar never advances
  wire bar_next = (bar_idx != last_bar) && (bar_pos == bar_width_bytes - 16'h0001);
  // R4 block wraps at programmed size
  wire [3:0] block_len = (block_size == 4'h0) ? 4'h1 : block_size;
  wire blk_wrap = (blk_idx == block_len - 4'h1);
  // R2 pattern choice; R15 colour registers
  wire [3:0] color_sel = solid_pattern_select ? blk_idx : {1'b0, bar_idx};
  wire ctpg_byte_t pay_byte = regs[slot(`CTPG_ADDR_COLOR0 + {4'h0, color_sel})];

  ctpg_byte_t hdr_byte;
  always_comb
  begin
    unique case (hdr_idx)
      2'h0: hdr_byte = {packet_virtual_channel, hdr_type};
      2'h1: hdr_byte = hdr_field[7:0];
      default: hdr_byte = hdr_field[15:8];
    endcase
  end

  wire out_first = (state != CTPG_PAY) && (hdr_idx == 2'h0);
  wire out_last = (state == CTPG_PAY) ? pay_done :
                  (hdr_done && (is_short || active_line_bytes == 16'h0000));
  assign gen_bus.valid = emitting;
  assign gen_bus.data = {out_first, out_last, (state == CTPG_PAY) ? pay_byte : hdr_byte};

  // Frame sequencer
  always_comb
  begin
    next_state = state;
    unique case (state)
      // R16 wait for a line boundary before a new frame
      CTPG_IDLE:
        if (generator_on && line_end)
          next_state = CTPG_FS;
      CTPG_FS:
        if (push && hdr_done)
          next_state = CTPG_TOP;
      // R13 frame start line plus top blank lines
      CTPG_TOP:
        if (line_end && blank_cnt == 8'h00)
          next_state = CTPG_HDR;
      CTPG_HDR:
        if (push && hdr_done)
          next_state = (active_line_bytes == 16'h0000) ? CTPG_ACTW : CTPG_PAY;
      CTPG_PAY:
        if (push && pay_done)
          next_state = CTPG_ACTW;
      // R12 next line only after the period ends
      CTPG_ACTW:
        if (line_end)
        begin
          if (!last_line)
            next_state = CTPG_HDR;
          // R14 bottom blank lines before frame end
          else if (bottom_blank_lines == 8'h00)
            next_state = CTPG_FE;
          else
            next_state = CTPG_BOT;
        end
      CTPG_BOT:
        if (line_end && blank_cnt == 8'h00)
          next_state = CTPG_FE;
      CTPG_FE:
        if (push && hdr_done)
          next_state = CTPG_IDLE;
    endcase
    // R1 disable stops between packets, never mid-packet
    if (!generator_on && (state == CTPG_TOP || state == CTPG_ACTW || state == CTPG_BOT))
      next_state = CTPG_IDLE;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state <= CTPG_IDLE;
    else
      state <= next_state;
  end

  // Header byte index
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      hdr_idx <= 2'h0;
    else if (push && state != CTPG_PAY)
      hdr_idx <= hdr_done ? 2'h0 : hdr_idx + 2'h1;
  end

  // Line payload position and bar counters
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pay_cnt <= 16'h0000;
      bar_idx <= 3'h0;
      bar_pos <= 16'h0000;
    end
    else if (state != CTPG_PAY)
    begin
      pay_cnt <= 16'h0000;
      bar_idx <= 3'h0;
      bar_pos <= 16'h0000;
    end
    else if (push)
    begin
      pay_cnt <= pay_cnt + 16'h0001;
      bar_idx <= bar_next ? bar_idx + 3'h1 : bar_idx;
      bar_pos <= bar_next ? 16'h0000 : bar_pos + 16'h0001;
    end
  end

  // R4 block position restarts every line
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      blk_idx <= 4'h0;
    else if (state != CTPG_PAY)
      blk_idx <= 4'h0;
    else if (push)
      blk_idx <= blk_wrap ? 4'h0 : blk_idx + 4'h1;
  end

  // Active line counter
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      line_idx <= 16'h0000;
    else if (state == CTPG_FS)
      line_idx <= 16'h0000;
    else if (state == CTPG_ACTW && line_end)
      line_idx <= line_idx + 16'h0001;
  end

  // Blank line counter shared by top and bottom blanking
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      blank_cnt <= 8'h00;
    else if (state == CTPG_FS)
      blank_cnt <= top_blank_lines;
    else if (state == CTPG_ACTW && line_end)
      blank_cnt <= bottom_blank_lines - 8'h01;
    else if ((state == CTPG_TOP || state == CTPG_BOT) && line_end && blank_cnt != 8'h00)
      blank_cnt <= blank_cnt - 8'h01;
  end

  // Frame number carried in the short packets, bumps after each frame end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      frame_num <= 16'h0000;
    else if (state == CTPG_FE && push && hdr_done)
      frame_num <= frame_num + 16'h0001;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      frame_active <= 1'b0;
    else
      frame_active <= (next_state != CTPG_IDLE);
  end
endmodule : ctpg_gen
`default_nettype wire

// ### ctpg_cfg.svh
// Register map, field positions, reset values and timing of the pattern generator
`ifndef CTPG_CFG_SVH
`define CTPG_CFG_SVH

`define CTPG_ADDR_CTL 8'h01
`define CTPG_ADDR_CFG 8'h02
`define CTPG_ADDR_IDS 8'h03
`define CTPG_ADDR_LINE_HI 8'h04
`define CTPG_ADDR_LINE_LO 8'h05
`define CTPG_ADDR_BAR_HI 8'h06
`define CTPG_ADDR_BAR_LO 8'h07
`define CTPG_ADDR_ACT_HI 8'h08
`define CTPG_ADDR_ACT_LO 8'h09
`define CTPG_ADDR_TOT_HI 8'h0A
`define CTPG_ADDR_TOT_LO 8'h0B
`define CTPG_ADDR_PD_HI 8'h0C
`define CTPG_ADDR_PD_LO 8'h0D
`define CTPG_ADDR_TOP 8'h0E
`define CTPG_ADDR_BOT 8'h0F
`define CTPG_ADDR_COLOR0 8'h10
`define CTPG_ADDR_LAST 8'h1E
`define CTPG_NUM_COLORS 15

`define CTPG_RST_CTL 8'h00
`define CTPG_RST_CFG 8'h33
`define CTPG_RST_IDS 8'h24
`define CTPG_RST_LINE_HI 8'h07
`define CTPG_RST_LINE_LO 8'h80
`define CTPG_RST_BAR_HI 8'h00
`define CTPG_RST_BAR_LO 8'hF0
`define CTPG_RST_ACT_HI 8'h01
`define CTPG_RST_ACT_LO 8'hE0
`define CTPG_RST_TOT_HI 8'h02
`define CTPG_RST_TOT_LO 8'h0D
`define CTPG_RST_PD_HI 8'h0C
`define CTPG_RST_PD_LO 8'h67
`define CTPG_RST_TOP 8'h21
`define CTPG_RST_BOT 8'h0A
`define CTPG_RST_COLOR0 8'hAA
`define CTPG_RST_COLOR1 8'h33

`define CTPG_MASK_CTL 8'h01
`define CTPG_MASK_CFG 8'hBF
`define CTPG_BIT_ENABLE 0
`define CTPG_BIT_SOLID 7
`define CTPG_BAR_CODE_HI 5
`define CTPG_BAR_CODE_LO 4
`define CTPG_BLOCK_HI 3
`define CTPG_BLOCK_LO 0
`define CTPG_VC_HI 7
`define CTPG_VC_LO 6
`define CTPG_DT_HI 5
`define CTPG_DT_LO 0

`define CTPG_DT_FRAME_START 6'h00
`define CTPG_DT_FRAME_END 6'h01
`define CTPG_HDR_BYTES 2'h3

`define CTPG_CLK_PERIOD_NS 100
`define CTPG_LINE_UNIT_NS 10
`define CTPG_TICKS_PER_CLK (`CTPG_CLK_PERIOD_NS / `CTPG_LINE_UNIT_NS)

`endif

// ### ctpg_pkg.sv
// Types shared by the pattern generator modules
package ctpg_pkg;
  typedef enum logic [2:0] {
    CTPG_IDLE, CTPG_FS, CTPG_TOP, CTPG_HDR, CTPG_PAY, CTPG_ACTW, CTPG_BOT, CTPG_FE
  } ctpg_state_t;
  typedef logic [7:0] ctpg_byte_t;
endpackage : ctpg_pkg

// ### ctpg_stream_if.sv
// Valid/ready byte stream between generator and its output buffer
`timescale 1ns/10ps
`default_nettype none
interface ctpg_stream_if #(parameter int WIDTH = 10);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ctpg_stream_if
`default_nettype wire

// ### ctpg_fifo.sv
// Output buffer: synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module ctpg_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Filling side
  ctpg_stream_if.snk wr,
  // Draining side
  ctpg_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  wire push = wr.valid && wr.ready;
  wire pop = rd.valid && rd.ready;

  assign wr.ready = (count != (AW+1)'(DEPTH));
  assign rd.valid = (count != '0);
  assign rd.data = mem[rptr];

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wptr] <= wr.data;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1;
      if (pop)
        rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ctpg_fifo
`default_nettype wire

// ### ctpg_line_timer.sv
// Line period timer counting in 10 ns units
`include "ctpg_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module ctpg_line_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic hold,
  input wire logic [15:0] period,
  // Event
  output logic line_end
);
  localparam logic [16:0] TICKS = 17'(`CTPG_TICKS_PER_CLK);
  logic [16:0] acc;
  wire [16:0] next_acc = acc + TICKS;

  // R12 period in 10 ns units
  assign line_end = !hold && (next_acc >= {1'b0, period});

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      acc <= '0;
    else if (hold || line_end)
      acc <= '0;
    else
      acc <= next_acc;
  end
endmodule : ctpg_line_timer
`default_nettype wire

// ### ctpg_gen_properties.sv
// Port checks for the pattern generator
`timescale 1ns/10ps
`default_nettype none
module ctpg_gen_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Stream and status
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_first,
  input wire logic tx_last,
  input wire logic frame_active
);
  logic [7:0] ids;
  wire take = tx_valid && tx_ready;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Shadow of the channel and type byte
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ids <= 8'h24;
    else if (reg_wr && reg_addr == 8'h03)
      ids <= reg_wdata;
  end
  sequence head_s;
    take && tx_first && tx_data[5:1] == 5'h00;
  endsequence
  sequence mid_s;
    take && !tx_first && !tx_last;
  endsequence
  sequence end_s;
    take && !tx_first && tx_last;
  endsequence
  stall_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
    && $stable({tx_first, tx_last})) else $error("stalled byte changed");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  ctl_rsvd_a: assert property (reg_rd && reg_addr == 8'h01 |=> reg_rdata[7:1] == 7'h00)
    else $error("control spare bits set");
  cfg_rsvd_a: assert property (reg_rd && reg_addr == 8'h02 |=> !reg_rdata[6])
    else $error("config spare bit set");
  unmapped_a: assert property (reg_rd && (reg_addr == 8'h00 || reg_addr > 8'h1E)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  vc_field_a: assert property (tx_valid && tx_first |-> tx_data[7:6] == ids[7:6])
    else $error("virtual channel wrong");
  dt_field_a: assert property (tx_valid && tx_first && tx_data[5:1] != 5'h00
    |-> tx_data[5:0] == ids[5:0]) else $error("data type wrong");
  fs_start_a: assert property ($rose(frame_active) && !tx_valid
    |-> ##[1:3] (tx_valid && tx_first && tx_data[5:0] == 6'h00)) else $error("no frame start");
  short_pkt_a: assert property (head_s |-> ##[1:5] mid_s ##[1:5] end_s)
    else $error("short packet not three bytes");
endmodule : ctpg_gen_properties
bind ctpg_gen ctpg_gen_properties u_props (.clk, .resetn, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .tx_valid, .tx_ready, .tx_data, .tx_first, .tx_last, .frame_active);
`default_nettype wire

// ### ctpg_sink_model.sv
// Transmitter stand-in: takes bytes with short random stalls
`timescale 1ns/10ps
`default_nettype none
module ctpg_sink_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Byte stream
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_first,
  input wire logic tx_last,
  // Long stall request
  input wire logic hold
);
  logic [9:0] q[$];
  int t[$];
  int cyc = 0;
  logic [15:0] lfsr = 16'hACE1;
  initial
    tx_ready = 1'b0;
  // Random stalls last a single cycle, longer ones only while hold is set, so line timing stays predictable
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    if (resetn && tx_valid && tx_ready)
    begin
      q.push_back({tx_first, tx_last, tx_data});
      t.push_back(cyc);
    end
    tx_ready <= resetn && !hold && (!tx_ready || lfsr[1:0] != 2'h0);
  end
endmodule : ctpg_sink_model
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the pattern generator
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import ctpg_pkg::*;
;
  logic clk, resetn, reg_wr, reg_rd, hold, tx_valid, tx_ready, tx_first, tx_last, frame_active;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_data, d, ids;
  logic [7:0] rst_tab [9] = '{8'h00, 8'h33, 8'h24, 8'h07, 8'h80, 8'h00, 8'hF0, 8'h01, 8'hE0};
  ctpg_byte_t col [15];
  logic [9:0] exp_q[$];
  logic [31:0] seed;
  int n_fail, compares, fnum, lbytes, bw, blk, f, i, lh;
  ctpg_gen dut (.clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .tx_valid, .tx_ready, .tx_data, .tx_first, .tx_last, .frame_active);
  ctpg_sink_model sink (.clk, .resetn, .tx_valid, .tx_ready, .tx_data, .tx_first, .tx_last, .hold);
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic test_done();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic cmp(input string n, input logic [9:0] e, input logic [9:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic cmp_gap(input string n, input int lo, input int hi, input int g);
    compares++;
    if (g < lo || g > hi)
    begin
      n_fail++;
      $display("mismatch %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask : cmp_gap
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // Kind 0 frame over, 1 frame on, 2 enough bytes taken
  task automatic wait_for(input int kind, input int n);
    int k;
    for (k = 0; k < 3000; k++)
    begin
      if (kind == 0 ? frame_active === 1'b0 : kind == 1 ? frame_active === 1'b1
          : sink.q.size() >= n)
        break;
      @(posedge clk);
    end
    if (k == 3000)
    begin
      n_fail++;
      $display("mismatch wait %0d expected done seen timeout", kind);
      test_done();
    end
  endtask : wait_for
  task automatic push3(input logic [7:0] b0, input logic [15:0] v, input bit short);
    exp_q.push_back({2'b10, b0});
    exp_q.push_back({2'b00, v[7:0]});
    exp_q.push_back({1'b0, short, v[15:8]});
  endtask : push3
  task automatic build(input bit solid, input int code);
    int k, b, nb;
    nb = (1 << code) - 1;
    push3({ids[7:6], 6'h00}, fnum[15:0], 1'b1);
    repeat (2)
    begin
      push3(ids, lbytes[15:0], 1'b0);
      for (k = 0; k < lbytes; k++)
      begin
        b = solid ? k % blk : (k / bw > nb ? nb : k / bw);
        exp_q.push_back({1'b0, k == lbytes - 1, col[b]});
      end
    end
    push3({ids[7:6], 6'h01}, fnum[15:0], 1'b1);
    fnum++;
  endtask : build
  initial
  begin
    seed = 32'h4694;
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    hold = 1'b0;
    n_fail = 0;
    compares = 0;
    fnum = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    for (i = 0; i < 9; i++)
    begin
      rd(i[7:0] + 8'h01);
      cmp("reset value", {2'b00, rst_tab[i]}, {2'b00, d});
    end
    rd(8'h30);
    cmp("unmapped", 10'h000, {2'b00, d});
    wr(8'h01, 8'hFE);
    rd(8'h01);
    cmp("control", 10'h000, {2'b00, d});
    wr(8'h02, 8'hFF);
    rd(8'h02);
    cmp("config", 10'h0BF, {2'b00, d});
    wr(8'h08, 8'h00);
    wr(8'h09, 8'h02);
    wr(8'h0C, 8'h01);
    wr(8'h0D, 8'h00);
    wr(8'h0E, 8'h01);
    wr(8'h0F, 8'h02);
    for (i = 0; i < 15; i++)
    begin
      col[i] = 8'(rnd());
      wr(8'h10 + i[7:0], col[i]);
    end
    for (f = 0; f < 5; f++)
    begin
      lbytes = 4 + rnd() % 9;
      bw = 1 + rnd() % 3;
      blk = 1 + rnd() % 15;
      ids = 8'(rnd());
      ids[4] = 1'b1;
      wr(8'h03, ids);
      wr(8'h04, lbytes[15:8]);
      wr(8'h05, lbytes[7:0]);
      wr(8'h06, bw[15:8]);
      wr(8'h07, bw[7:0]);
      wr(8'h02, {f == 4, 1'b0, f[1:0], blk[3:0]});
      build(f == 4, f % 4);
      wr(8'h01, 8'h01);
      // Fixed-colour frame also fills the buffer behind a long stall
      if (f == 4)
      begin
        wait_for(2, 4);
        hold <= 1'b1;
        repeat (50) @(posedge clk);
        hold <= 1'b0;
      end
      wait_for(1, 0);
      wait_for(0, 0);
      wr(8'h01, 8'h00);
      wait_for(2, exp_q.size());
      foreach (exp_q[j])
        cmp("stream byte", exp_q[j], sink.q[j]);
      lh = 6 + lbytes;
      if (f < 4)
      begin
        cmp_gap("line period", 23, 29, sink.t[lh] - sink.t[3]);
        cmp_gap("top blank", 48, 55, sink.t[3] - sink.t[0]);
        cmp_gap("bottom blank", 73, 81, sink.t[lh + lbytes + 3] - sink.t[lh]);
      end
      sink.q.delete();
      sink.t.delete();
      exp_q.delete();
    end
    repeat (100) @(posedge clk);
    cmp("idle bytes", 10'h000, 10'(sink.q.size()));
    // Disable during top blanking: frame start only, no frame end
    wr(8'h01, 8'h01);
    wait_for(1, 0);
    repeat (40) @(posedge clk);
    wr(8'h01, 8'h00);
    repeat (100) @(posedge clk);
    cmp("cut frame bytes", 10'h003, 10'(sink.q.size()));
    cmp("cut frame active", 10'h000, {9'h000, frame_active});
    cmp("cut frame start", {2'b01, fnum[15:8]}, sink.q[2]);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
